/* File: design/capture_channel_pkg.sv */
/*
 File holds the register map, field layouts, encodings and state type of one
 timer capture channel.
 Assumes an APB slave with 32-bit data; every register is one aligned word.
*/
package capture_channel_pkg;

   // ****************************************************************
   // Register byte offsets
   // ****************************************************************
   localparam logic [7:0] OFS_CHAN_CTRL  = 8'h00;
   localparam logic [7:0] OFS_CHAN_MODE  = 8'h04;
   localparam logic [7:0] OFS_COUNTER    = 8'h10;
   localparam logic [7:0] OFS_CAP_A      = 8'h14;
   localparam logic [7:0] OFS_CAP_B      = 8'h18;
   localparam logic [7:0] OFS_COMPARE_C  = 8'h1C;
   localparam logic [7:0] OFS_STATUS     = 8'h20;
   localparam logic [7:0] OFS_IRQ_MASK   = 8'h24;
   localparam logic [7:0] OFS_CAP_AB     = 8'h28;
   localparam logic [7:0] OFS_BLOCK_CTRL = 8'h40;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int CTRL_CLK_EN     = 0;
   localparam int CTRL_CLK_DIS    = 1;
   localparam int CTRL_SOFT_TRIG  = 2;
   localparam int BLOCK_SYNC      = 0;
   localparam int MODE_CLK_LSB    = 0;
   localparam int MODE_EXT_EDGE_LSB = 8;
   localparam int MODE_EXT_SRC_LSB  = 10;
   localparam int MODE_EXT_TRIG_EN  = 12;
   localparam int MODE_RC_TRIG_EN   = 14;
   localparam int MODE_WAVE         = 15;
   localparam int MODE_LDA_LSB      = 16;
   localparam int MODE_LDB_LSB      = 18;
   localparam int MODE_SUBS_LSB     = 20;
   localparam int MODE_WIDTH        = 23;
   localparam int ST_OVERRUN   = 0;
   localparam int ST_LOAD_A    = 1;
   localparam int ST_LOAD_B    = 2;
   localparam int ST_RC_MATCH  = 3;
   localparam int ST_EXT_TRIG  = 4;
   localparam int ST_CLK_ON    = 16;
   localparam int ST_LINE_A    = 17;
   localparam int ST_LINE_B    = 18;
   localparam int EVENT_WIDTH  = 5;

   // ****************************************************************
   // Encodings and reset values
   // ****************************************************************
   localparam logic [1:0] EDGE_NONE    = 2'h0;
   localparam logic [1:0] EDGE_RISE    = 2'h1;
   localparam logic [1:0] EDGE_FALL    = 2'h2;
   localparam logic [1:0] EDGE_BOTH    = 2'h3;
   localparam logic [2:0] CLK_PERIPH   = 3'h0;
   localparam logic [2:0] CLK_EXT0     = 3'h5;
   localparam logic [2:0] CLK_EXT1     = 3'h6;
   localparam logic [2:0] CLK_EXT2     = 3'h7;
   localparam logic [1:0] SRC_EXT0     = 2'h0;
   localparam logic [1:0] SRC_EXT1     = 2'h1;
   localparam logic [1:0] SRC_EXT2     = 2'h2;
   localparam logic [1:0] SRC_LINE_B   = 2'h3;
   localparam logic [2:0] SUBS_MAX     = 3'h4;
   localparam logic [31:0] MODE_RESET  = 32'h0000_0000;
   localparam logic [31:0] CNT_ZERO    = 32'h0000_0000;
   localparam logic [31:0] READ_ZERO   = 32'h0000_0000;

   typedef enum logic [2:0]
   {
      AB_EMPTY = 3'b001,
      AB_A_OLD = 3'b010,
      AB_B_OLD = 3'b100
   } ab_order_t;

   typedef struct packed
   {
      logic [4:0] event_bits;
   } events_t;

endpackage : capture_channel_pkg

/* File: design/timer_capture_channel.sv */
/*
 File holds one timer channel: counter, trigger sources, capture A/B with
 edge selection, subsampling, load ordering, overrun and combined readout.
 Assumes an APB master on clk; the line and external clock pins are asynchronous and resynchronised.
*/
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Mode bit selects capture or waveform
// - Capture mode: lines A, B are inputs
// - Waveform: drive A; B unless trigger
// - Trigger clears counter, starts counter clock
// - Trigger acts at next counter clock edge
// - Control register bit gives software trigger
// - Block sync acts as software trigger
// - Compare C match triggers when enabled
// - External trigger source per mode; enable bit used in waveform only
// - Capture mode treats lines as inputs
// - Line A edges load capture A, B
// - Subsample selected edges by 1..16
// - A loads first, or after B
// - B loads only after A
// - Unread reload sets overrun, overwrites value
// - Combined register returns oldest unread value
// - Each capture load raises DMA request
module timer_capture_channel
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        channel_line_a_in,
   output logic             channel_line_a_out,
   output logic             channel_line_a_oe,
   input  wire logic        channel_line_b_in,
   output logic             channel_line_b_out,
   output logic             channel_line_b_oe,
   input  wire logic        ext_clock_in_0,
   input  wire logic        ext_clock_in_1,
   input  wire logic        ext_clock_in_2,
   output logic             dma_req,
   output logic             irq
);

   // ****************************************************************
   // Input synchronisers
   // ****************************************************************
   logic [4:0] sync1_reg;
   logic [4:0] sync2_reg;
   logic [4:0] sync3_reg;
   logic [4:0] sync1_next;
   logic [4:0] sync2_next;
   logic [4:0] sync3_next;
   logic       line_a;
   logic       line_b;
   logic [2:0] xc;
   logic [2:0] xc_prev;

   always_comb
   begin
      sync1_next = {ext_clock_in_2, ext_clock_in_1, ext_clock_in_0,
                    channel_line_b_in, channel_line_a_in};
      sync2_next = sync1_reg;
      sync3_next = sync2_reg;
   end

   always_ff @(posedge clk)
   begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      sync3_reg <= sync3_next;
   end

   assign line_a  = sync2_reg[0];
   assign line_b  = sync2_reg[1];
   assign xc      = sync2_reg[4:2];
   assign xc_prev = sync3_reg[4:2];

   function automatic logic edge_hit(input logic [1:0] sel, input logic now,
                                     input logic old);
      edge_hit = ((sel == capture_channel_pkg::EDGE_RISE) && now && !old) ||
                 ((sel == capture_channel_pkg::EDGE_FALL) && !now && old) ||
                 ((sel == capture_channel_pkg::EDGE_BOTH) && (now != old));
   endfunction : edge_hit

   // ****************************************************************
   // State and next values
   // ****************************************************************
   logic [31:0] mode_reg,   mode_next;
   logic [31:0] cnt_reg,    cnt_next;
   logic [31:0] rc_reg,     rc_next;
   logic [31:0] cap_a_reg,  cap_a_next;
   logic [31:0] cap_b_reg,  cap_b_next;
   logic [4:0]  status_reg, status_next;
   logic [4:0]  mask_reg,   mask_next;
   logic        clk_on_reg, clk_on_next;
   logic        trig_pend_reg, trig_pend_next;
   logic        a_done_reg, a_done_next;
   logic        a_unread_reg, a_unread_next;
   logic        b_unread_reg, b_unread_next;
   logic [3:0]  subs_reg,   subs_next;
   logic [31:0] prdata_next;
   logic        pready_next;
   logic        pslverr_next;
   logic        dma_next;
   logic        irq_next;
   logic        a_oe_next;
   logic        b_oe_next;
   capture_channel_pkg::ab_order_t order_reg, order_next;

   logic        wave;
   logic        wr;
   logic        rd;
   logic        tick;
   logic        trig_src;
   logic        ext_ev;
   logic        a_edge;
   logic        b_edge;
   logic        subs_ok;
   logic        load_a;
   logic        load_b;
   logic [3:0]  subs_last;
   logic [2:0]  cksel;
   logic [1:0]  ext_sel;
   logic        ext_line;
   logic        ext_line_old;

   assign wave = mode_reg[capture_channel_pkg::MODE_WAVE];
   assign wr   = psel && penable && !pready && pwrite;
   assign rd   = psel && penable && !pready && !pwrite;

   always_comb
   begin
      cksel = mode_reg[capture_channel_pkg::MODE_CLK_LSB +: 3];
      case (cksel)
         capture_channel_pkg::CLK_EXT0: tick = xc[0] && !xc_prev[0];
         capture_channel_pkg::CLK_EXT1: tick = xc[1] && !xc_prev[1];
         capture_channel_pkg::CLK_EXT2: tick = xc[2] && !xc_prev[2];
         default:                       tick = 1'b1;
      endcase
   end

   // ****************************************************************
   // Trigger sources
   // ****************************************************************
   always_comb
   begin
      ext_sel = mode_reg[capture_channel_pkg::MODE_EXT_SRC_LSB +: 2];
      if (!wave)
      begin
         ext_line     = ext_sel[0] ? line_b : line_a;
         ext_line_old = ext_sel[0] ? sync3_reg[1] : sync3_reg[0];
      end
      else
      begin
         case (ext_sel)
            capture_channel_pkg::SRC_EXT0:
            begin
               ext_line = xc[0];
               ext_line_old = xc_prev[0];
            end
            capture_channel_pkg::SRC_EXT1:
            begin
               ext_line = xc[1];
               ext_line_old = xc_prev[1];
            end
            capture_channel_pkg::SRC_EXT2:
            begin
               ext_line = xc[2];
               ext_line_old = xc_prev[2];
            end
            default:
            begin
               ext_line = line_b;
               ext_line_old = sync3_reg[1];
            end
         endcase
      end
      ext_ev = edge_hit(mode_reg[capture_channel_pkg::MODE_EXT_EDGE_LSB +: 2],
                        ext_line, ext_line_old) &&
               (!wave || mode_reg[capture_channel_pkg::MODE_EXT_TRIG_EN]);
      trig_src = (wr && paddr == capture_channel_pkg::OFS_CHAN_CTRL &&
                  pwdata[capture_channel_pkg::CTRL_SOFT_TRIG]) ||
                 (wr && paddr == capture_channel_pkg::OFS_BLOCK_CTRL &&
                  pwdata[capture_channel_pkg::BLOCK_SYNC]) ||
                 (mode_reg[capture_channel_pkg::MODE_RC_TRIG_EN] &&
                  cnt_reg == rc_reg) ||
                 ext_ev;
   end

   // ****************************************************************
   // Counter and capture logic
   // ****************************************************************
   always_comb
   begin
      mode_next      = mode_reg;
      rc_next        = rc_reg;
      mask_next      = mask_reg;
      cnt_next       = cnt_reg;
      clk_on_next    = clk_on_reg;
      trig_pend_next = trig_pend_reg || trig_src;
      cap_a_next     = cap_a_reg;
      cap_b_next     = cap_b_reg;
      a_done_next    = a_done_reg;
      a_unread_next  = a_unread_reg;
      b_unread_next  = b_unread_reg;
      subs_next      = subs_reg;
      order_next     = order_reg;
      status_next    = status_reg;
      prdata_next    = capture_channel_pkg::READ_ZERO;
      pslverr_next   = 1'b0;
      load_a         = 1'b0;
      load_b         = 1'b0;
      subs_last      = 4'h0;

      if (tick && trig_pend_reg)
      begin
         cnt_next       = capture_channel_pkg::CNT_ZERO;
         clk_on_next    = 1'b1;
         trig_pend_next = trig_src;
         a_done_next    = 1'b0;
         subs_next      = 4'h0;
      end
      else if (tick && clk_on_reg)
      begin
         cnt_next = cnt_reg + 32'h0000_0001;
      end

      a_edge = edge_hit(mode_reg[capture_channel_pkg::MODE_LDA_LSB +: 2],
                        line_a, sync3_reg[0]);
      b_edge = edge_hit(mode_reg[capture_channel_pkg::MODE_LDB_LSB +: 2],
                        line_a, sync3_reg[0]);
      if (mode_reg[capture_channel_pkg::MODE_SUBS_LSB +: 3] > capture_channel_pkg::SUBS_MAX)
         subs_last = 4'hF;
      else
         subs_last = 4'((5'h01 << mode_reg[capture_channel_pkg::MODE_SUBS_LSB +: 3]) - 5'h01);
      subs_ok = (subs_reg >= subs_last);
      if (!wave && (a_edge || b_edge) && !(tick && trig_pend_reg))
      begin
         subs_next = subs_ok ? 4'h0 : subs_reg + 4'h1;
         load_a = subs_ok && a_edge && !a_done_reg;
         load_b = subs_ok && b_edge && a_done_reg && !load_a;
      end

      if (rd && paddr == capture_channel_pkg::OFS_CAP_A)
         a_unread_next = 1'b0;
      if (rd && paddr == capture_channel_pkg::OFS_CAP_B)
         b_unread_next = 1'b0;
      if (rd && paddr == capture_channel_pkg::OFS_CAP_AB)
      begin
         if (order_reg == capture_channel_pkg::AB_A_OLD)
            a_unread_next = 1'b0;
         else
            b_unread_next = 1'b0;
      end
      if (!a_unread_next && !b_unread_next)
         order_next = capture_channel_pkg::AB_EMPTY;
      else if (!a_unread_next)
         order_next = capture_channel_pkg::AB_B_OLD;
      else if (!b_unread_next)
         order_next = capture_channel_pkg::AB_A_OLD;

      // Clear first so that an event in the same cycle wins
      if (wr && paddr == capture_channel_pkg::OFS_STATUS)
         status_next = status_reg & ~pwdata[capture_channel_pkg::EVENT_WIDTH-1:0];
      if (load_a)
      begin
         cap_a_next    = cnt_reg;
         a_done_next   = 1'b1;
         a_unread_next = 1'b1;
         if (!b_unread_next)
            order_next = capture_channel_pkg::AB_A_OLD;
         status_next[capture_channel_pkg::ST_LOAD_A] = 1'b1;
      end
      if (load_b)
      begin
         cap_b_next    = cnt_reg;
         a_done_next   = 1'b0;
         b_unread_next = 1'b1;
         if (!a_unread_next)
            order_next = capture_channel_pkg::AB_B_OLD;
         status_next[capture_channel_pkg::ST_LOAD_B] = 1'b1;
      end

      if ((load_a && a_unread_reg) || (load_b && b_unread_reg))
         status_next[capture_channel_pkg::ST_OVERRUN] = 1'b1;
      if (cnt_reg == rc_reg)
         status_next[capture_channel_pkg::ST_RC_MATCH] = 1'b1;
      if (ext_ev)
         status_next[capture_channel_pkg::ST_EXT_TRIG] = 1'b1;

      if (wr)
      begin
         case (paddr)
            capture_channel_pkg::OFS_CHAN_CTRL:
            begin
               if (pwdata[capture_channel_pkg::CTRL_CLK_DIS])
                  clk_on_next = 1'b0;
            end
            capture_channel_pkg::OFS_CHAN_MODE:
               mode_next = {9'h000, pwdata[capture_channel_pkg::MODE_WIDTH-1:0]};
            capture_channel_pkg::OFS_COMPARE_C: rc_next = pwdata;
            capture_channel_pkg::OFS_IRQ_MASK:  mask_next = pwdata[4:0];
            capture_channel_pkg::OFS_STATUS:    ;
            capture_channel_pkg::OFS_BLOCK_CTRL: ;
            default: pslverr_next = 1'b1;
         endcase
      end
      if (rd)
      begin
         case (paddr)
            capture_channel_pkg::OFS_CHAN_MODE: prdata_next = mode_reg;
            capture_channel_pkg::OFS_COUNTER:   prdata_next = cnt_reg;
            capture_channel_pkg::OFS_CAP_A:     prdata_next = cap_a_reg;
            capture_channel_pkg::OFS_CAP_B:     prdata_next = cap_b_reg;
            capture_channel_pkg::OFS_COMPARE_C: prdata_next = rc_reg;
            capture_channel_pkg::OFS_IRQ_MASK:  prdata_next = {27'h0, mask_reg};
            capture_channel_pkg::OFS_STATUS:
               prdata_next = {13'h0, line_b, line_a, clk_on_reg, 11'h0, status_reg};
            capture_channel_pkg::OFS_CAP_AB:
               prdata_next = (order_reg == capture_channel_pkg::AB_A_OLD) ?
                             cap_a_reg : cap_b_reg;
            capture_channel_pkg::OFS_CHAN_CTRL:  ;
            capture_channel_pkg::OFS_BLOCK_CTRL: ;
            default: pslverr_next = 1'b1;
         endcase
      end
      pready_next = psel && penable && !pready;
      dma_next    = load_a || load_b;
      irq_next    = |(status_next & mask_next);
      a_oe_next   = mode_next[capture_channel_pkg::MODE_WAVE];
      b_oe_next   = mode_next[capture_channel_pkg::MODE_WAVE] &&
                    !(mode_next[capture_channel_pkg::MODE_EXT_SRC_LSB +: 2] ==
                      capture_channel_pkg::SRC_LINE_B);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         mode_reg      <= capture_channel_pkg::MODE_RESET;
         cnt_reg       <= capture_channel_pkg::CNT_ZERO;
         rc_reg        <= capture_channel_pkg::CNT_ZERO;
         cap_a_reg     <= capture_channel_pkg::CNT_ZERO;
         cap_b_reg     <= capture_channel_pkg::CNT_ZERO;
         status_reg    <= 5'h00;
         mask_reg      <= 5'h00;
         clk_on_reg    <= 1'b0;
         trig_pend_reg <= 1'b0;
         a_done_reg    <= 1'b0;
         a_unread_reg  <= 1'b0;
         b_unread_reg  <= 1'b0;
         subs_reg      <= 4'h0;
         order_reg     <= capture_channel_pkg::AB_EMPTY;
         prdata        <= capture_channel_pkg::READ_ZERO;
         pready        <= 1'b0;
         pslverr       <= 1'b0;
         dma_req       <= 1'b0;
         irq           <= 1'b0;
         channel_line_a_oe <= 1'b0;
         channel_line_b_oe <= 1'b0;
      end
      else
      begin
         mode_reg      <= mode_next;
         cnt_reg       <= cnt_next;
         rc_reg        <= rc_next;
         cap_a_reg     <= cap_a_next;
         cap_b_reg     <= cap_b_next;
         status_reg    <= status_next;
         mask_reg      <= mask_next;
         clk_on_reg    <= clk_on_next;
         trig_pend_reg <= trig_pend_next;
         a_done_reg    <= a_done_next;
         a_unread_reg  <= a_unread_next;
         b_unread_reg  <= b_unread_next;
         subs_reg      <= subs_next;
         order_reg     <= order_next;
         prdata        <= prdata_next;
         pready        <= pready_next;
         pslverr       <= pslverr_next;
         dma_req       <= dma_next;
         irq           <= irq_next;
         channel_line_a_oe <= a_oe_next;
         channel_line_b_oe <= b_oe_next;
      end
   end

   always_ff @(posedge clk)
   begin
      channel_line_a_out <= 1'b0;
      channel_line_b_out <= 1'b0;
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   sequence s_trig_taken;
      tick && trig_pend_reg;
   endsequence

   property p_trig_clears;
      @(posedge clk) disable iff (rst)
         s_trig_taken |=> (cnt_reg == capture_channel_pkg::CNT_ZERO) && clk_on_reg;
   endproperty
   a_trig_clears: assert property (p_trig_clears) else $error("trigger did not clear");

   property p_trig_waits;
      @(posedge clk) disable iff (rst) trig_src |=> trig_pend_reg;
   endproperty
   a_trig_waits: assert property (p_trig_waits) else $error("trigger lost");

   property p_soft;
      @(posedge clk) disable iff (rst)
         (wr && paddr == capture_channel_pkg::OFS_CHAN_CTRL &&
          pwdata[capture_channel_pkg::CTRL_SOFT_TRIG]) |=>
         trig_pend_reg || cnt_reg == capture_channel_pkg::CNT_ZERO;
   endproperty
   a_soft: assert property (p_soft) else $error("soft trigger ignored");

   property p_sync;
      @(posedge clk) disable iff (rst)
         (wr && paddr == capture_channel_pkg::OFS_BLOCK_CTRL &&
          pwdata[capture_channel_pkg::BLOCK_SYNC]) |-> trig_src;
   endproperty
   a_sync: assert property (p_sync) else $error("sync ignored");

   property p_rc;
      @(posedge clk) disable iff (rst)
         (mode_reg[capture_channel_pkg::MODE_RC_TRIG_EN] && cnt_reg == rc_reg) |-> trig_src;
   endproperty
   a_rc: assert property (p_rc) else $error("rc match ignored");

   property p_capture_inputs;
      @(posedge clk) disable iff (rst)
         !$past(mode_reg[capture_channel_pkg::MODE_WAVE]) &&
         !mode_reg[capture_channel_pkg::MODE_WAVE] |->
         !channel_line_a_oe && !channel_line_b_oe;
   endproperty
   a_capture_inputs: assert property (p_capture_inputs) else $error("line driven in capture");

   property p_b_after_a;
      @(posedge clk) disable iff (rst) load_b |-> a_done_reg;
   endproperty
   a_b_after_a: assert property (p_b_after_a) else $error("b loaded early");

   property p_a_order;
      @(posedge clk) disable iff (rst) load_a |-> !a_done_reg;
   endproperty
   a_a_order: assert property (p_a_order) else $error("a loaded twice");

   property p_overrun;
      @(posedge clk) disable iff (rst)
         (load_a && a_unread_reg) || (load_b && b_unread_reg) |=>
         status_reg[capture_channel_pkg::ST_OVERRUN];
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun missed");

   property p_dma;
      @(posedge clk) disable iff (rst) (load_a || load_b) |=> dma_req;
   endproperty
   a_dma: assert property (p_dma) else $error("dma request missing");

   property p_dma_idle;
      @(posedge clk) disable iff (rst) !(load_a || load_b) |=> !dma_req;
   endproperty
   a_dma_idle: assert property (p_dma_idle) else $error("dma request without load");

endmodule : timer_capture_channel

`default_nettype wire

/* File: verification/line_model.sv */
/*
 Drives the capture channel's input pins from outside.
 Assumes the bench sets the levels of lines A and B; the clocks stay idle.
*/
`timescale 1ns/10ps
`default_nettype none
module line_model
(
   input  wire logic clk,
   input  wire logic a_req,
   input  wire logic b_req,
   output logic      line_a,
   output logic      line_b,
   output logic      ext_clk
);
   // Each level is held many clocks so the channel sees it
   always @(posedge clk) line_a <= a_req;
   always @(posedge clk) line_b <= b_req;
   assign ext_clk = 1'b0;
endmodule : line_model
`default_nettype wire

/* File: verification/tb_top.sv */
/*
 Self-checking bench for the timer capture channel over APB.
 Assumes line_model drives the pins and reads answer one cycle after access.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        clk, rst, psel, penable, pwrite, a_req, b_req, se;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, r1, r2, seed;
   logic        pready, pslverr, oe_a, oe_b, dma_req, irq, la, lb, xc;
   int          errors, n_compared, dmas;
   logic [31:0] exp_q[$];

   line_model line_model_inst (.clk(clk), .a_req(a_req), .b_req(b_req), .line_a(la),
      .line_b(lb), .ext_clk(xc));
   timer_capture_channel timer_capture_channel_inst (.clk(clk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .channel_line_a_in(la), .channel_line_a_out(),
      .channel_line_a_oe(oe_a), .channel_line_b_in(lb), .channel_line_b_out(),
      .channel_line_b_oe(oe_b), .ext_clock_in_0(xc), .ext_clock_in_1(xc),
      .ext_clock_in_2(xc), .dma_req(dma_req), .irq(irq));

   initial
   begin
      clk = 1'b0;
      forever #25 clk = !clk;
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb

   task automatic rdx(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask : rdx

   task automatic line(input logic v);
      a_req <= v;
      repeat (8) @(posedge clk);
   endtask : line

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   task automatic test_done;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : test_done

   always @(posedge clk)
   begin
      if (dma_req === 1'b1)
         dmas++;
      if (pready === 1'b1 && psel === 1'b1 && pwrite === 1'b0 && exp_q.size() > 0)
         check(prdata, exp_q.pop_front(), "read data");
   end

   initial
   begin
      repeat (5000) @(posedge clk);
      errors++;
      test_done();
   end

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   initial
   begin
      rst = 1'b1;
      {psel, penable, pwrite, a_req, b_req, paddr, pwdata} = '0;
      seed = 32'hC2BC;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdx(capture_channel_pkg::OFS_CHAN_MODE, capture_channel_pkg::MODE_RESET);
      apb(1'b0, 8'h3C, 32'h0);
      check({31'h0, se}, 32'h1, "slverr");
      check({30'h0, oe_a, oe_b}, 32'h0, "capture oe");
      apb(1'b1, capture_channel_pkg::OFS_CHAN_MODE, 32'h0009_0000);
      apb(1'b1, capture_channel_pkg::OFS_IRQ_MASK, 32'h0000_0001);
      apb(1'b1, capture_channel_pkg::OFS_CHAN_CTRL, 32'h0000_0005);
      line(1'b1);
      line(1'b0);
      check(dmas, 2, "dma count");
      apb(1'b0, capture_channel_pkg::OFS_CAP_AB, 32'h0);
      r1 = rd;
      apb(1'b0, capture_channel_pkg::OFS_CAP_AB, 32'h0);
      r2 = rd;
      check({31'h0, r2 > r1}, 32'h1, "load order");
      rdx(capture_channel_pkg::OFS_CAP_A, r1);
      rdx(capture_channel_pkg::OFS_CAP_B, r2);
      check({31'h0, irq}, 32'h0, "irq idle");
      line(1'b1);
      line(1'b0);
      line(1'b1);
      check(dmas, 5, "dma count");
      apb(1'b0, capture_channel_pkg::OFS_STATUS, 32'h0);
      check(rd & 32'h1, 32'h1, "overrun");
      check({31'h0, irq}, 32'h1, "irq set");
      apb(1'b1, capture_channel_pkg::OFS_STATUS, 32'h0000_0001);
      @(posedge clk);
      check({31'h0, irq}, 32'h0, "irq cleared");
      apb(1'b1, capture_channel_pkg::OFS_BLOCK_CTRL, 32'h0000_0001);
      line(1'b0);
      check(dmas, 5, "b before a");
      apb(1'b1, capture_channel_pkg::OFS_CHAN_MODE, 32'h0011_0500);
      apb(1'b0, capture_channel_pkg::OFS_STATUS, 32'h0);
      check(rd & 32'h10, 32'h0, "ext trigger idle");
      b_req <= 1'b1;
      repeat (8) @(posedge clk);
      b_req <= 1'b0;
      apb(1'b0, capture_channel_pkg::OFS_STATUS, 32'h0);
      check(rd & 32'h10, 32'h10, "ext trigger");
      line(1'b1);
      line(1'b0);
      check(dmas, 5, "subsample skip");
      line(1'b1);
      line(1'b0);
      check(dmas, 6, "subsample load");
      repeat (3)
      begin
         seed = xs(seed);
         apb(1'b1, capture_channel_pkg::OFS_COMPARE_C, seed);
         rdx(capture_channel_pkg::OFS_COMPARE_C, seed);
      end
      apb(1'b1, capture_channel_pkg::OFS_CHAN_MODE, 32'h0000_8000);
      repeat (3) @(posedge clk);
      check({30'h0, oe_a, oe_b}, 32'h3, "wave oe");
      apb(1'b1, capture_channel_pkg::OFS_CHAN_MODE, 32'h0000_8C00);
      repeat (3) @(posedge clk);
      check({30'h0, oe_a, oe_b}, 32'h2, "wave oe trig b");
      test_done();
   end
endmodule : tb_top
`default_nettype wire
